// >>> hw/lie_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module lie_edge_det #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] sig_i,
	output logic      [WIDTH-1:0] rise_o,
	output logic      [WIDTH-1:0] toggle_o
);
	logic [WIDTH-1:0] prev_q;
	logic [WIDTH-1:0] prev_d;

	always_comb begin
		prev_d   = sig_i;
		rise_o   = sig_i & ~prev_q;
		toggle_o = sig_i ^ prev_q;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prev_q <= '0;
		end else begin
			prev_q <= prev_d;
		end
	end
endmodule : lie_edge_det
`default_nettype wire

// >>> hw/lie_event_reg.sv
// Function
// - set new-cycle event whenever the cycle number low bit toggles.
// - set phy event when the phy requests an interrupt in a status transfer.
// - set bus-reset event when the phy reports entering bus reset.
// - set self-id-done event at end of initialisation, only if self-id acceptance enabled.
// - self-id-done event is forced to zero when bus-reset event becomes set.
// - set lock reply failure event when lock reply retries are exhausted.
// - set buffered write failure event on host bus error storing acked write.
// - on buffered write failure capture destination offset and source node.
// - iso receive summary is unlatched OR of context events and enables.
// - iso transmit summary is unlatched OR of context events and enables, read-only.
// - set reply-packet event after each packet stored in a reply buffer.
// - set request-packet event after each packet stored in a request buffer.
// - set reply-buffer-done event when a reply receive descriptor completes.
// - set request-buffer-done event when a request receive descriptor completes.
// - set reply-send-done event when reply transmit finishes last descriptor.
// - set request-send-done event when request transmit finishes last descriptor.
// - software cannot clear bus-reset event during the self-id phase.
// - events set by source edge or set-address write; cleared via clear address, and self-id-done also when bus-reset event becomes set.
// - set address reads raw events; clear address reads events ANDed with enables.
// - interrupt asserted when any event bit and its enable are both set.
// - global gate zero suppresses interrupts without changing clear-address reads.
`timescale 1ns/1ps
`default_nettype none
module lie_event_reg (
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	input  wire lie_pkg::lie_apb_req_type   apb_i,
	output logic [31:0]                     prdata_o,
	output logic                            pready_o,
	output logic                            pslverr_o,
	input  wire lie_pkg::lie_sources_type   sources_i,
	input  wire lie_pkg::lie_fail_info_type fail_info_i,
	input  wire logic                       self_id_phase_i,
	input  wire logic [7:0]                 iso_receive_context_events_i,
	input  wire logic [7:0]                 iso_receive_context_enables_i,
	input  wire logic [7:0]                 iso_transmit_context_events_i,
	input  wire logic [7:0]                 iso_transmit_context_enables_i,
	output logic                            accept_self_identification_o,
	output logic                            irq_o
);
	import lie_pkg::*;

	logic [31:0]       events_q;
	logic [31:0]       events_d;
	logic [31:0]       enables_q;
	logic [31:0]       enables_d;
	logic [31:0]       link_q;
	logic [31:0]       link_d;
	lie_fail_info_type fail_loc_q;
	lie_fail_info_type fail_loc_d;
	logic              irq_q;
	logic              irq_d;
	logic [31:0]       prdata_q;
	logic [31:0]       prdata_d;
	logic              pready_q;
	logic              pready_d;
	logic              pslverr_q;
	logic              pslverr_d;

	logic [SOURCE_COUNT-1:0] rise_v;
	logic [SOURCE_COUNT-1:0] toggle_v;
	lie_sources_type         rise_s;
	lie_sources_type         toggle_s;

	logic        addr_hit;
	logic        access_first;
	logic        commit;
	logic        wr_ev_set;
	logic        wr_ev_clr;
	logic        wr_en_set;
	logic        wr_en_clr;
	logic        wr_link;
	logic [31:0] hw_set;
	logic [31:0] sw_set;
	logic [31:0] sw_clr;
	logic [31:0] events_view;
	logic        iso_rx_sum;
	logic        iso_tx_sum;

	lie_edge_det #(
		.WIDTH (SOURCE_COUNT)
	) u_edge (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.sig_i    (sources_i),
		.rise_o   (rise_v),
		.toggle_o (toggle_v)
	);

	assign rise_s   = lie_sources_type'(rise_v);
	assign toggle_s = lie_sources_type'(toggle_v);

	// apb decode: one wait state, so read data can come straight from a flop
	always_comb begin
		addr_hit = (apb_i.paddr == OFF_EVENTS_SET) || (apb_i.paddr == OFF_EVENTS_CLEAR)
			|| (apb_i.paddr == OFF_ENABLES_SET) || (apb_i.paddr == OFF_ENABLES_CLEAR)
			|| (apb_i.paddr == OFF_FAIL_LOC_LO) || (apb_i.paddr == OFF_FAIL_LOC_HI)
			|| (apb_i.paddr == OFF_LINK_SETTINGS);
		access_first = apb_i.psel && apb_i.penable && !pready_q;
		commit       = apb_i.psel && apb_i.penable && pready_q && apb_i.pwrite && !pslverr_q;
		wr_ev_set    = commit && (apb_i.paddr == OFF_EVENTS_SET);
		wr_ev_clr    = commit && (apb_i.paddr == OFF_EVENTS_CLEAR);
		wr_en_set    = commit && (apb_i.paddr == OFF_ENABLES_SET);
		wr_en_clr    = commit && (apb_i.paddr == OFF_ENABLES_CLEAR);
		wr_link      = commit && (apb_i.paddr == OFF_LINK_SETTINGS);
	end

	// unlatched iso summaries
	always_comb begin
		iso_rx_sum = |(iso_receive_context_events_i & iso_receive_context_enables_i);
		iso_tx_sum = |(iso_transmit_context_events_i & iso_transmit_context_enables_i);
		events_view = events_q & EVENT_LATCH_BITS;
		events_view[BIT_ISO_RX] = iso_rx_sum;
		events_view[BIT_ISO_TX] = iso_tx_sum;
	end

	always_comb begin
		hw_set = '0;
		hw_set[BIT_NEW_CYCLE]    = toggle_s.cycle_lsb;
		hw_set[BIT_PHY]          = rise_s.phy_irq;
		hw_set[BIT_BUS_RESET]    = rise_s.bus_reset;
		hw_set[BIT_SELF_ID_DONE] = rise_s.self_id_done && link_q[BIT_ACCEPT_SELF_ID];
		hw_set[BIT_LOCK_FAIL]    = rise_s.lock_fail;
		hw_set[BIT_WRITE_FAIL]   = rise_s.write_fail;
		hw_set[BIT_REPLY_PKT]    = rise_s.reply_pkt;
		hw_set[BIT_REQUEST_PKT]  = rise_s.request_pkt;
		hw_set[BIT_REPLY_BUF]    = rise_s.reply_buf;
		hw_set[BIT_REQUEST_BUF]  = rise_s.request_buf;
		hw_set[BIT_REPLY_SEND]   = rise_s.reply_send;
		hw_set[BIT_REQUEST_SEND] = rise_s.request_send;

		// reserved and read-only bits masked off
		sw_set = wr_ev_set ? (apb_i.pwdata & EVENT_LATCH_BITS) : '0;
		sw_clr = wr_ev_clr ? (apb_i.pwdata & EVENT_LATCH_BITS) : '0;
		if (self_id_phase_i) begin
			sw_clr[BIT_BUS_RESET] = 1'b0;
		end
		// set beats a clear in the same cycle
		events_d = ((events_q & ~sw_clr) | hw_set | sw_set) & EVENT_LATCH_BITS;
		if (events_d[BIT_BUS_RESET] && !events_q[BIT_BUS_RESET]) begin
			events_d[BIT_SELF_ID_DONE] = 1'b0;
		end

		enables_d = enables_q;
		if (wr_en_set) begin
			enables_d = enables_q | (apb_i.pwdata & ENABLE_BITS);
		end else if (wr_en_clr) begin
			enables_d = enables_q & ~(apb_i.pwdata & ENABLE_BITS);
		end

		link_d = wr_link ? (apb_i.pwdata & LINK_BITS) : link_q;

		fail_loc_d = fail_loc_q;
		if (rise_s.write_fail) begin
			fail_loc_d = fail_info_i;
		end

		// any enabled event raises the request while the global gate is set
		irq_d = enables_q[BIT_GLOBAL_GATE] && |(events_view & enables_q & EVENT_READ_BITS);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			events_q   <= EVENTS_RESET;
			enables_q  <= ENABLES_RESET;
			link_q     <= LINK_RESET;
			fail_loc_q <= lie_fail_info_type'(FAIL_LOC_RESET);
			irq_q      <= 1'b0;
		end else begin
			events_q   <= events_d;
			enables_q  <= enables_d;
			link_q     <= link_d;
			fail_loc_q <= fail_loc_d;
			irq_q      <= irq_d;
		end
	end

	// read path, sampled on the first access cycle
	always_comb begin
		prdata_d  = prdata_q;
		pready_d  = access_first;
		pslverr_d = 1'b0;
		if (access_first) begin
			pslverr_d = !addr_hit;
			unique case (apb_i.paddr)
				OFF_EVENTS_SET:    prdata_d = events_view;
				OFF_EVENTS_CLEAR:  prdata_d = events_view & enables_q & EVENT_READ_BITS;
				OFF_ENABLES_SET,
				OFF_ENABLES_CLEAR: prdata_d = enables_q;
				OFF_FAIL_LOC_LO:   prdata_d = fail_loc_q.dest_offset[31:0];
				OFF_FAIL_LOC_HI:   prdata_d = {fail_loc_q.source_node, fail_loc_q.dest_offset[47:32]};
				OFF_LINK_SETTINGS: prdata_d = link_q;
				default:           prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata_o                     = prdata_q;
	assign pready_o                     = pready_q;
	assign pslverr_o                    = pslverr_q;
	assign irq_o                        = irq_q;
	assign accept_self_identification_o = link_q[BIT_ACCEPT_SELF_ID];

	a_cycle_toggle_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(toggle_s.cycle_lsb && !wr_ev_clr) |=> events_q[BIT_NEW_CYCLE])
		else $error("new-cycle event missed a toggle");

	a_phy_event_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sources_i.phy_irq) |=> events_q[BIT_PHY])
		else $error("phy event not set");

	a_bus_reset_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sources_i.bus_reset) |=> events_q[BIT_BUS_RESET])
		else $error("bus reset event not set");

	a_self_id_gated: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(events_q[BIT_SELF_ID_DONE]) |->
			$past(rise_s.self_id_done && link_q[BIT_ACCEPT_SELF_ID]) || $past(wr_ev_set))
		else $error("self-id event set without cause");

	a_reset_wipes_self: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(events_q[BIT_BUS_RESET]) |-> !events_q[BIT_SELF_ID_DONE])
		else $error("self-id survived bus reset");

	a_fail_loc_capture: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		rise_s.write_fail |=> (fail_loc_q == $past(fail_info_i)) && events_q[BIT_WRITE_FAIL])
		else $error("failed write location not captured");

	a_iso_summary_live: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		access_first && (apb_i.paddr == OFF_EVENTS_SET) |=>
			prdata_q[BIT_ISO_RX] == $past(iso_rx_sum) && prdata_q[BIT_ISO_TX] == $past(iso_tx_sum))
		else $error("iso summary read wrong");

	a_bus_reset_held: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		self_id_phase_i && events_q[BIT_BUS_RESET] |=> events_q[BIT_BUS_RESET])
		else $error("bus reset cleared during self-id phase");

	a_clear_only_sw: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(events_q[BIT_PHY]) |-> $past(wr_ev_clr && apb_i.pwdata[BIT_PHY]))
		else $error("event fell without a clear write");

	a_irq_follows: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		enables_q[BIT_GLOBAL_GATE] && events_q[BIT_REQUEST_SEND] && enables_q[BIT_REQUEST_SEND]
			|=> irq_o)
		else $error("interrupt not raised");

	a_gate_blocks: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!enables_q[BIT_GLOBAL_GATE] |=> !irq_o)
		else $error("interrupt raised with gate closed");

	a_reserved_zero: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		pready_q && !pslverr_q && ($past(apb_i.paddr) == OFF_EVENTS_SET) |->
			prdata_q[18] == 1'b0 && prdata_q[15:10] == 6'h00 && prdata_q[31:21] == 11'h000)
		else $error("reserved event bits not zero");

	a_self_id_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sources_i.self_id_done) && link_q[BIT_ACCEPT_SELF_ID] && !$rose(sources_i.bus_reset)
			&& !wr_ev_set |=> events_q[BIT_SELF_ID_DONE])
		else $error("self-id event not set");

	a_lock_fail_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sources_i.lock_fail) |=> events_q[BIT_LOCK_FAIL])
		else $error("lock reply failure event not set");

	a_write_fail_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sources_i.write_fail) |=> events_q[BIT_WRITE_FAIL])
		else $error("buffered write failure event not set");

	a_reply_pkt_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sources_i.reply_pkt) |=> events_q[BIT_REPLY_PKT])
		else $error("reply packet event not set");

	a_request_pkt_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sources_i.request_pkt) |=> events_q[BIT_REQUEST_PKT])
		else $error("request packet event not set");

	a_reply_buf_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sources_i.reply_buf) |=> events_q[BIT_REPLY_BUF])
		else $error("reply buffer event not set");

	a_request_buf_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sources_i.request_buf) |=> events_q[BIT_REQUEST_BUF])
		else $error("request buffer event not set");

	a_reply_send_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sources_i.reply_send) |=> events_q[BIT_REPLY_SEND])
		else $error("reply send event not set");

	a_request_send_sets: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sources_i.request_send) |=> events_q[BIT_REQUEST_SEND])
		else $error("request send event not set");

	a_enable_reserved_zero: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		enables_q[18] == 1'b0 && enables_q[15:10] == 6'h00 && enables_q[30:21] == 10'h000)
		else $error("reserved enable bits set");
endmodule : lie_event_reg
`default_nettype wire

// >>> shared/lie_pkg.sv
`default_nettype none
package lie_pkg;

	// register byte offsets on the apb port
	localparam logic [11:0] OFF_EVENTS_SET    = 12'h080;
	localparam logic [11:0] OFF_EVENTS_CLEAR  = 12'h084;
	localparam logic [11:0] OFF_ENABLES_SET   = 12'h088;
	localparam logic [11:0] OFF_ENABLES_CLEAR = 12'h08c;
	localparam logic [11:0] OFF_FAIL_LOC_LO   = 12'h090;
	localparam logic [11:0] OFF_FAIL_LOC_HI   = 12'h094;
	localparam logic [11:0] OFF_LINK_SETTINGS = 12'h0a0;

	// event bit positions
	localparam int unsigned BIT_NEW_CYCLE     = 20;
	localparam int unsigned BIT_PHY           = 19;
	localparam int unsigned BIT_BUS_RESET     = 17;
	localparam int unsigned BIT_SELF_ID_DONE  = 16;
	localparam int unsigned BIT_LOCK_FAIL     = 9;
	localparam int unsigned BIT_WRITE_FAIL    = 8;
	localparam int unsigned BIT_ISO_RX        = 7;
	localparam int unsigned BIT_ISO_TX        = 6;
	localparam int unsigned BIT_REPLY_PKT     = 5;
	localparam int unsigned BIT_REQUEST_PKT   = 4;
	localparam int unsigned BIT_REPLY_BUF     = 3;
	localparam int unsigned BIT_REQUEST_BUF   = 2;
	localparam int unsigned BIT_REPLY_SEND    = 1;
	localparam int unsigned BIT_REQUEST_SEND  = 0;
	localparam int unsigned BIT_GLOBAL_GATE   = 31;
	localparam int unsigned BIT_ACCEPT_SELF_ID = 9;

	// latched, readable and enable-capable bit sets
	localparam logic [31:0] EVENT_LATCH_BITS  = 32'h001b_033f;
	localparam logic [31:0] EVENT_READ_BITS   = 32'h001b_03ff;
	localparam logic [31:0] ENABLE_BITS       = 32'h801b_03ff;
	localparam logic [31:0] LINK_BITS         = 32'h0000_0200;

	// reset values
	localparam logic [31:0] EVENTS_RESET      = 32'h0000_0000;
	localparam logic [31:0] ENABLES_RESET     = 32'h0000_0000;
	localparam logic [31:0] LINK_RESET        = 32'h0000_0000;
	localparam logic [63:0] FAIL_LOC_RESET    = 64'h0000_0000_0000_0000;

	localparam int unsigned SOURCE_COUNT      = 12;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} lie_apb_req_type;

	// level sources; an asserting edge is the event (cycle_lsb: any change)
	typedef struct packed {
		logic cycle_lsb;
		logic phy_irq;
		logic bus_reset;
		logic self_id_done;
		logic lock_fail;
		logic write_fail;
		logic reply_pkt;
		logic request_pkt;
		logic reply_buf;
		logic request_buf;
		logic reply_send;
		logic request_send;
	} lie_sources_type;

	typedef struct packed {
		logic [15:0] source_node;
		logic [47:0] dest_offset;
	} lie_fail_info_type;

endpackage : lie_pkg
`default_nettype wire

// >>> test/lie_host_irq_model.sv
`timescale 1ns/1ps
`default_nettype none
module lie_host_irq_model (
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	input  wire logic   irq_i,
	output int unsigned irq_count_o
);
	logic irq_prev_q;
	// a level input; the host sees each new request once, on its rising edge
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_prev_q  <= 1'b0;
			irq_count_o <= 0;
		end else begin
			irq_prev_q <= irq_i;
			if (irq_i && !irq_prev_q) begin
				irq_count_o <= irq_count_o + 1;
			end
		end
	end
endmodule : lie_host_irq_model
`default_nettype wire

// >>> test/link_interrupt_event_register_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module link_interrupt_event_register_tb_top;
	import lie_pkg::*;
	logic              clk_i;
	logic              rst_n_q;
	lie_apb_req_type   apb_q;
	lie_sources_type   src_q;
	lie_fail_info_type fail_q;
	logic              phase_q;
	logic [7:0]        rx_ev_q;
	logic [7:0]        rx_en_q;
	logic [7:0]        tx_ev_q;
	logic [7:0]        tx_en_q;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              accept;
	logic              irq;
	int unsigned       irq_count;
	int                errors;
	int                n_compared;
	logic [31:0]       rd;
	logic              se;
	int unsigned       pos [12] = '{20, 19, 17, 16, 9, 8, 5, 4, 3, 2, 1, 0};

	lie_event_reg u_lie_event_reg (
		.clk_i                          (clk_i),
		.rst_n_i                        (rst_n_q),
		.apb_i                          (apb_q),
		.prdata_o                       (prdata),
		.pready_o                       (pready),
		.pslverr_o                      (pslverr),
		.sources_i                      (src_q),
		.fail_info_i                    (fail_q),
		.self_id_phase_i                (phase_q),
		.iso_receive_context_events_i   (rx_ev_q),
		.iso_receive_context_enables_i  (rx_en_q),
		.iso_transmit_context_events_i  (tx_ev_q),
		.iso_transmit_context_enables_i (tx_en_q),
		.accept_self_identification_o   (accept),
		.irq_o                          (irq)
	);

	lie_host_irq_model u_lie_host_irq_model (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_q),
		.irq_i       (irq),
		.irq_count_o (irq_count)
	);

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// entered just after a rising edge; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_i);
		apb_q.penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			give_verdict();
		end
		rd = prdata;
		se = pslverr;
		apb_q <= '0;
		@(posedge clk_i);
	endtask : apb

	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
	endtask : rdchk

	task automatic pulse(input int i);
		src_q[11-i] <= 1'b1;
		@(posedge clk_i);
		src_q[11-i] <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : pulse

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_cycles

	initial begin
		errors = 0;
		n_compared = 0;
		rst_n_q = 1'b0;
		apb_q = '0;
		src_q = '0;
		fail_q = '{source_node: 16'h1234, dest_offset: 48'habcd_5678_9abc};
		phase_q = 1'b0;
		rx_ev_q = 8'h00;
		rx_en_q = 8'h00;
		tx_ev_q = 8'h00;
		tx_en_q = 8'h00;
		wait_cycles(5);
		rst_n_q <= 1'b1;
		@(posedge clk_i);
		rdchk("events raw", OFF_EVENTS_SET, 32'h0000_0000);
		rdchk("enables", OFF_ENABLES_SET, 32'h0000_0000);
		apb(1'b0, 12'h0fc, 32'h0000_0000);
		chk("unmapped error", 32'h1, {31'h0, se});
		$display("test reset done");

		apb(1'b1, OFF_LINK_SETTINGS, 32'h0000_0200);
		chk("accept self id", 32'h1, {31'h0, accept});
		for (int i = 0; i < 12; i++) begin
			pulse(i);
			rdchk("source event", OFF_EVENTS_SET, 32'h1 << pos[i]);
			apb(1'b1, OFF_EVENTS_CLEAR, 32'h1 << pos[i]);
			rdchk("after clear", OFF_EVENTS_SET, 32'h0000_0000);
		end
		rdchk("fail offset", OFF_FAIL_LOC_LO, 32'h5678_9abc);
		rdchk("fail node", OFF_FAIL_LOC_HI, 32'h1234_abcd);
		$display("test sources done");

		apb(1'b1, OFF_LINK_SETTINGS, 32'h0000_0000);
		pulse(3);
		rdchk("self id gated", OFF_EVENTS_SET, 32'h0000_0000);
		apb(1'b1, OFF_LINK_SETTINGS, 32'h0000_0200);
		pulse(3);
		pulse(2);
		rdchk("bus reset kills self id", OFF_EVENTS_SET, 32'h0002_0000);
		phase_q <= 1'b1;
		apb(1'b1, OFF_EVENTS_CLEAR, 32'h0002_0000);
		rdchk("clear refused", OFF_EVENTS_SET, 32'h0002_0000);
		phase_q <= 1'b0;
		// transmit sources stay idle while the bus reset event is cleared
		apb(1'b1, OFF_EVENTS_CLEAR, 32'h0002_0000);
		rdchk("clear after phase", OFF_EVENTS_SET, 32'h0000_0000);
		$display("test bus reset done");

		apb(1'b1, OFF_EVENTS_SET, 32'hffff_ffff);
		rdchk("software set", OFF_EVENTS_SET, EVENT_LATCH_BITS & 32'hfffe_ffff);
		apb(1'b1, OFF_EVENTS_CLEAR, 32'hffff_ffff);
		rdchk("software clear", OFF_EVENTS_SET, 32'h0000_0000);
		apb(1'b1, OFF_ENABLES_SET, 32'hffff_ffff);
		rdchk("enables reserved", OFF_ENABLES_CLEAR, ENABLE_BITS);
		apb(1'b1, OFF_ENABLES_CLEAR, 32'hffff_ffff);
		rdchk("enables cleared", OFF_ENABLES_SET, 32'h0000_0000);
		$display("test software access done");

		apb(1'b1, OFF_EVENTS_SET, 32'h0000_0001);
		apb(1'b1, OFF_ENABLES_SET, 32'h0000_0001);
		rdchk("masked read", OFF_EVENTS_CLEAR, 32'h0000_0001);
		chk("gate closed", 32'h0, {31'h0, irq});
		apb(1'b1, OFF_ENABLES_SET, 32'h8000_0000);
		wait_cycles(3);
		chk("irq raised", 32'h1, {31'h0, irq});
		chk("host saw one", 32'h1, irq_count);
		apb(1'b1, OFF_ENABLES_CLEAR, 32'h0000_0001);
		wait_cycles(3);
		chk("irq masked", 32'h0, {31'h0, irq});
		rdchk("masked read zero", OFF_EVENTS_CLEAR, 32'h0000_0000);
		rdchk("raw read", OFF_EVENTS_SET, 32'h0000_0001);
		$display("test masking done");

		apb(1'b1, OFF_EVENTS_CLEAR, 32'h0000_0001);
		rx_ev_q <= 8'h21;
		rx_en_q <= 8'h20;
		tx_ev_q <= 8'h01;
		tx_en_q <= 8'h02;
		wait_cycles(2);
		rdchk("iso summaries", OFF_EVENTS_SET, 32'h0000_0080);
		apb(1'b1, OFF_EVENTS_CLEAR, 32'h0000_00c0);
		rdchk("summary not cleared", OFF_EVENTS_SET, 32'h0000_0080);
		tx_en_q <= 8'h03;
		rx_en_q <= 8'h00;
		wait_cycles(2);
		rdchk("summaries live", OFF_EVENTS_SET, 32'h0000_0040);
		$display("test iso summaries done");
		give_verdict();
	end
endmodule : link_interrupt_event_register_tb_top
`default_nettype wire
